/* hdl/ecg_lead_dp.sv */
// Our own choices: strobed register access and the register addresses.
module ecg_lead_dp import ecg_pkg::*; #(
  parameter int CH = NCH,
  parameter int DW = ADC_W,
  parameter int AW = ACC_W,
  parameter int OW = OUT_W
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  // Register port
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA,
  // Converters
  output logic O_CONV_START,
  input wire logic I_ADC_VLD,
  input wire logic [CH-1:0][DW-1:0] I_ADC_DATA,
  // Frame words
  output logic O_FRM_VLD,
  output logic [31:0] O_FRM_HDR,
  output logic [CH-1:0][OW-1:0] O_FRM_WORD,
  // Interrupt
  output logic O_IRQ
);
  localparam int EW = AW + 1;

  ecg_smp_if #(.CH(CH), .AW(AW)) smp ();

  logic [7:0] conv_cnt_ff;
  logic diff_sel_ff;
  logic cm_ref_ff;
  logic fmt_ff;
  logic [1:0] rate_ff;
  logic [DW-1:0] uth_ff;
  logic [DW-1:0] lth_ff;
  logic [AW-1:0] ref_ff;
  logic [2:0] sts_ff;
  logic [2:0] irq_en_ff;
  logic [31:0] rdata_ff;
  logic [CH-1:0] hit;
  logic oor_win_ff;
  logic signed [EW-1:0] c_ff [CH];
  logic s1_vld_ff;
  logic ana_s_ff;
  logic elec_s_ff;
  logic err_s_ff;
  logic oor_s_ff;
  logic [1:0] rate_s_ff;
  logic signed [OW-1:0] w [CH];
  logic signed [EW+1:0] sum3;
  logic signed [EW+11:0] prod;
  logic signed [EW+1:0] cterm;
  logic elec_now;
  logic err_now;
  logic [2:0] sts_set;
  logic [2:0] sts_clr;

  // Conversion start every 2 MHz period
  // Registered so the converters see a clean one-cycle pulse
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      conv_cnt_ff <= 8'h00;
      O_CONV_START <= 1'b0;
    end else begin
      O_CONV_START <= (conv_cnt_ff == 8'(CONV_CYC - 1));
      conv_cnt_ff <= (conv_cnt_ff == 8'(CONV_CYC - 1)) ? 8'h00 : conv_cnt_ff + 8'h01;
    end
  end

  ecg_ovs #(.CH(CH), .DW(DW), .AW(AW)) u_ovs (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_rate(rate_ff),
    .i_vld(I_ADC_VLD),
    .i_smp(I_ADC_DATA),
    .smp(smp.src)
  );

  // Configuration registers
  // Bits outside each field are dropped on write and read back as zero
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      diff_sel_ff <= 1'b0;
      cm_ref_ff <= 1'b0;
      fmt_ff <= 1'b0;
      rate_ff <= RATE_2K;
      uth_ff <= UTH_RST;
      lth_ff <= LTH_RST;
      ref_ff <= REF_RST;
      irq_en_ff <= 3'h0;
    end else if (I_REG_WR) begin
      case (I_REG_ADDR)
        REG_ECG_CTL: diff_sel_ff <= I_REG_WDATA[CTL_DIFF_BIT];
        REG_CMREF: cm_ref_ff <= I_REG_WDATA[CMREF_CE_BIT];
        REG_FRM_CTL: begin
          fmt_ff <= I_REG_WDATA[FRM_FMT_BIT];
          rate_ff <= I_REG_WDATA[FRM_RATE_LSB +: 2];
        end
        REG_UTH: uth_ff <= I_REG_WDATA[DW-1:0];
        REG_LTH: lth_ff <= I_REG_WDATA[DW-1:0];
        REG_REF: ref_ff <= I_REG_WDATA[AW-1:0];
        REG_IRQ_EN: irq_en_ff <= I_REG_WDATA[2:0];
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      rdata_ff <= 32'h0000_0000;
    end else if (I_REG_RD) begin
      rdata_ff <= 32'h0000_0000;
      case (I_REG_ADDR)
        REG_ECG_CTL: rdata_ff[CTL_DIFF_BIT] <= diff_sel_ff;
        REG_CMREF: rdata_ff[CMREF_CE_BIT] <= cm_ref_ff;
        REG_FRM_CTL: begin
          rdata_ff[FRM_FMT_BIT] <= fmt_ff;
          rdata_ff[FRM_RATE_LSB +: 2] <= rate_ff;
        end
        REG_UTH: rdata_ff[DW-1:0] <= uth_ff;
        REG_LTH: rdata_ff[DW-1:0] <= lth_ff;
        REG_REF: rdata_ff[AW-1:0] <= ref_ff;
        REG_STS: rdata_ff[2:0] <= sts_ff;
        REG_IRQ_EN: rdata_ff[2:0] <= irq_en_ff;
        default: ;
      endcase
    end
  end
  assign O_REG_RDATA = rdata_ff;

  // Range check on every raw sample, before any summing hides it
  // A single rail hit is enough; summing would dilute it below the threshold
  for (genvar g = 0; g < CH; g++) begin : g_thr
    assign hit[g] = (I_ADC_DATA[g] > uth_ff) || (I_ADC_DATA[g] < lth_ff);
  end

  // Window flag restarts with each dump; a hit in that cycle opens the next one
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      oor_win_ff <= 1'b0;
    end else if (smp.vld) begin
      oor_win_ff <= I_ADC_VLD && (|hit);
    end else if (I_ADC_VLD && (|hit)) begin
      oor_win_ff <= 1'b1;
    end
  end

  // 128 kHz without analog leads falls back to electrode words
  assign err_now = !fmt_ff && !diff_sel_ff && (smp.rate == RATE_128K);
  assign elec_now = fmt_ff || err_now;

  // Snapshot of one window with the reference removed from every channel
  // Mode bits are caught with the data, so a mid-window write cannot split a frame
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      s1_vld_ff <= 1'b0;
      ana_s_ff <= 1'b0;
      elec_s_ff <= 1'b0;
      err_s_ff <= 1'b0;
      oor_s_ff <= 1'b0;
      rate_s_ff <= RATE_2K;
      for (int i = 0; i < CH; i++) begin
        c_ff[i] <= '0;
      end
    end else begin
      s1_vld_ff <= smp.vld;
      if (smp.vld) begin
        ana_s_ff <= diff_sel_ff;
        elec_s_ff <= elec_now;
        err_s_ff <= err_now;
        oor_s_ff <= oor_win_ff;
        rate_s_ff <= smp.rate;
        for (int i = 0; i < CH; i++) begin
          c_ff[i] <= $signed({1'b0, smp.acc[i]}) - $signed({1'b0, ref_ff});
        end
      end
    end
  end

  // Central terminal from the three limb electrodes
  // 341/1024 stands in for one third, within a part in a thousand
  always_comb begin
    sum3 = (EW+2)'(c_ff[CH_RA]) + (EW+2)'(c_ff[CH_LA]) + (EW+2)'(c_ff[CH_LL]);
    prod = (EW+12)'(sum3) * (EW+12)'(signed'(CTERM_MUL));
    cterm = (EW+2)'(prod >>> CTERM_SHIFT);
  end

  // Word selection per mode
  always_comb begin
    for (int i = 0; i < CH; i++) begin
      w[i] = OW'(c_ff[i]);
    end
    if (!elec_s_ff && ana_s_ff) begin
      // Input stage already formed the leads
      w[1] = -OW'(c_ff[1]);
    end else if (!elec_s_ff) begin
      // Common-mode setting plays no part here
      w[0] = OW'(c_ff[CH_LA]) - OW'(c_ff[CH_RA]);
      w[1] = OW'(c_ff[CH_LL]) - OW'(c_ff[CH_RA]);
      w[2] = OW'(c_ff[CH_LL]) - OW'(c_ff[CH_LA]);
      w[3] = OW'(c_ff[CH_V1]) - OW'(cterm);
      w[4] = OW'(c_ff[CH_V2]) - OW'(cterm);
    end
  end

  // Frame output registers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_FRM_VLD <= 1'b0;
      O_FRM_HDR <= 32'h0000_0000;
      O_FRM_WORD <= '0;
    end else begin
      O_FRM_VLD <= s1_vld_ff;
      if (s1_vld_ff) begin
        O_FRM_HDR <= 32'h0000_0000;
        O_FRM_HDR[HDR_OOR_BIT] <= oor_s_ff;
        O_FRM_HDR[HDR_ELEC_BIT] <= elec_s_ff;
        O_FRM_HDR[HDR_ANA_BIT] <= ana_s_ff;
        O_FRM_HDR[HDR_RATE_LSB +: 2] <= rate_s_ff;
        O_FRM_HDR[HDR_ERR_BIT] <= err_s_ff;
        for (int i = 0; i < CH; i++) begin
          O_FRM_WORD[i] <= w[i];
        end
      end
    end
  end

  // Sticky status; a set in the clear cycle survives
  // Clear is write-one; zero bits in the clear word leave status alone
  assign sts_set[STS_FRM_BIT] = O_FRM_VLD;
  assign sts_set[STS_OOR_BIT] = O_FRM_VLD && O_FRM_HDR[HDR_OOR_BIT];
  assign sts_set[STS_ERR_BIT] = O_FRM_VLD && O_FRM_HDR[HDR_ERR_BIT];
  assign sts_clr = (I_REG_WR && (I_REG_ADDR == REG_IRQ_CLR)) ? I_REG_WDATA[2:0] : 3'h0;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sts_ff <= 3'h0;
    end else begin
      sts_ff <= (sts_ff & ~sts_clr) | sts_set;
    end
  end

  // Level interrupt
  assign O_IRQ = |(sts_ff & irq_en_ff);

  // Checks on pacing, snapshot, frame and status; the frame-word checks compare against the snapshot one cycle back
  // Conversion pacing and analog lead words
  AST_CONV_PERIOD: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_CONV_START |-> ##125 O_CONV_START)
    else $error("conversion start not periodic");

  AST_ANA_INVERT: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s1_vld_ff && ana_s_ff && !elec_s_ff |=> $signed(O_FRM_WORD[1]) == -OW'($past(c_ff[1])))
    else $error("second analog lead not negated");

  AST_ANA_PASS: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s1_vld_ff && ana_s_ff && !elec_s_ff |=> $signed(O_FRM_WORD[0]) == OW'($past(c_ff[0])))
    else $error("first analog lead altered");

  // Reference removal
  AST_REF_SUB: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    smp.vld |=> c_ff[0] == $signed({1'b0, $past(smp.acc[0])}) - $signed({1'b0, $past(ref_ff)}))
    else $error("reference not removed");

  // Digital limb and chest leads
  AST_LEAD_I: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s1_vld_ff && !ana_s_ff && !elec_s_ff
    |=> $signed(O_FRM_WORD[0]) == OW'($past(c_ff[CH_LA])) - OW'($past(c_ff[CH_RA])))
    else $error("lead one wrong");

  AST_LEAD_II: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s1_vld_ff && !ana_s_ff && !elec_s_ff
    |=> $signed(O_FRM_WORD[1]) == OW'($past(c_ff[CH_LL])) - OW'($past(c_ff[CH_RA])))
    else $error("lead two wrong");

  AST_LEAD_III: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s1_vld_ff && !ana_s_ff && !elec_s_ff
    |=> $signed(O_FRM_WORD[2]) == OW'($past(c_ff[CH_LL])) - OW'($past(c_ff[CH_LA])))
    else $error("lead three wrong");

  AST_CHEST: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s1_vld_ff && !ana_s_ff && !elec_s_ff
    |=> $signed(O_FRM_WORD[3]) == OW'($past(c_ff[CH_V1])) - OW'($past(cterm)))
    else $error("chest lead wrong");

  AST_CHEST_V2: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s1_vld_ff && !ana_s_ff && !elec_s_ff
    |=> $signed(O_FRM_WORD[4]) == OW'($past(c_ff[CH_V2])) - OW'($past(cterm)))
    else $error("second chest lead wrong");

  // Rate rules and the electrode fallback
  AST_NO_DIG_128K: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_FRM_VLD && !O_FRM_HDR[HDR_ANA_BIT] && O_FRM_HDR[HDR_RATE_LSB +: 2] == RATE_128K
    |-> O_FRM_HDR[HDR_ELEC_BIT])
    else $error("digital leads at 128 kHz");

  AST_FALLBACK: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_FRM_VLD && O_FRM_HDR[HDR_ERR_BIT]
    |-> O_FRM_HDR[HDR_ELEC_BIT] && (O_FRM_HDR[HDR_RATE_LSB +: 2] == RATE_128K))
    else $error("fallback outside 128 kHz");

  AST_RATE_HDR: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s1_vld_ff |=> O_FRM_VLD && (O_FRM_HDR[HDR_RATE_LSB +: 2] == $past(rate_s_ff)))
    else $error("frame rate field wrong");

  // Range flag from raw sample to header and status, and frame status clear
  AST_OOR_HDR: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    smp.vld && oor_win_ff |-> ##2 O_FRM_VLD && O_FRM_HDR[HDR_OOR_BIT])
    else $error("range flag lost");

  AST_OOR_HOLD: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    oor_win_ff && !smp.vld |=> oor_win_ff)
    else $error("range flag dropped inside window");

  AST_THR: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_ADC_VLD && !smp.vld && (I_ADC_DATA[0] > uth_ff) |=> oor_win_ff)
    else $error("upper threshold missed");

  AST_STS_OOR: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    O_FRM_VLD && O_FRM_HDR[HDR_OOR_BIT] |=> sts_ff[STS_OOR_BIT])
    else $error("range status not set");

  AST_IRQ_CLR: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    I_REG_WR && (I_REG_ADDR == REG_IRQ_CLR) && I_REG_WDATA[STS_FRM_BIT] && !O_FRM_VLD
    |=> !sts_ff[STS_FRM_BIT])
    else $error("frame status not cleared");

  // Electrode words and frame hold
  AST_ELEC_PASS: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    s1_vld_ff && elec_s_ff |=> $signed(O_FRM_WORD[0]) == OW'($past(c_ff[0])))
    else $error("electrode word altered");

  AST_FRM_HOLD: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    !s1_vld_ff |=> $stable(O_FRM_WORD) && $stable(O_FRM_HDR))
    else $error("frame words moved between frames");

  // Main scenarios
  COV_ANA: cover property (@(posedge I_CORE_CLK) O_FRM_VLD && O_FRM_HDR[HDR_ANA_BIT]);
  COV_DIG: cover property (@(posedge I_CORE_CLK) s1_vld_ff && !ana_s_ff && !elec_s_ff);
  COV_ERR: cover property (@(posedge I_CORE_CLK) O_FRM_VLD && O_FRM_HDR[HDR_ERR_BIT]);
  COV_IRQ: cover property (@(posedge I_CORE_CLK) O_IRQ);
  COV_OOR: cover property (@(posedge I_CORE_CLK) O_FRM_VLD && O_FRM_HDR[HDR_OOR_BIT]);
endmodule

/* hdl/ecg_pkg.sv */
package ecg_pkg;

  // Datapath sizes
  localparam int NCH = 5;
  localparam int ADC_W = 14;
  localparam int ACC_W = 24;
  localparam int OUT_W = 32;

  // Channel order at the converter inputs
  localparam int CH_LA = 0;
  localparam int CH_LL = 1;
  localparam int CH_RA = 2;
  localparam int CH_V1 = 3;
  localparam int CH_V2 = 4;

  // Conversion pacing, 2 MHz against a 4 ns core clock
  localparam int CORE_PERIOD_PS = 4000;
  localparam int CONV_PERIOD_PS = 500000;
  localparam int CONV_CYC = CONV_PERIOD_PS / CORE_PERIOD_PS;

  // Samples summed per output word at each rate
  localparam int OVS_2K = 1024;
  localparam int OVS_16K = 128;
  localparam int OVS_128K = 16;
  localparam logic [1:0] RATE_2K = 2'h0;
  localparam logic [1:0] RATE_16K = 2'h1;
  localparam logic [1:0] RATE_128K = 2'h2;

  // Register offsets
  localparam logic [7:0] REG_ECG_CTL = 8'h01;
  localparam logic [7:0] REG_CMREF = 8'h05;
  localparam logic [7:0] REG_FRM_CTL = 8'h0a;
  localparam logic [7:0] REG_UTH = 8'h20;
  localparam logic [7:0] REG_LTH = 8'h21;
  localparam logic [7:0] REG_REF = 8'h22;
  localparam logic [7:0] REG_STS = 8'h30;
  localparam logic [7:0] REG_IRQ_EN = 8'h31;
  localparam logic [7:0] REG_IRQ_CLR = 8'h32;

  // Field positions
  localparam int CTL_DIFF_BIT = 10;
  localparam int CMREF_CE_BIT = 8;
  localparam int FRM_FMT_BIT = 4;
  localparam int FRM_RATE_LSB = 0;
  localparam int HDR_OOR_BIT = 0;
  localparam int HDR_ELEC_BIT = 1;
  localparam int HDR_ANA_BIT = 2;
  localparam int HDR_RATE_LSB = 3;
  localparam int HDR_ERR_BIT = 5;
  localparam int STS_FRM_BIT = 0;
  localparam int STS_OOR_BIT = 1;
  localparam int STS_ERR_BIT = 2;

  // Reset values
  localparam logic [13:0] UTH_RST = 14'h3f00;
  localparam logic [13:0] LTH_RST = 14'h00ff;
  localparam logic [23:0] REF_RST = 24'h5c71c7;

  // Central terminal scale, 341/1024 = 0.333
  localparam int CTERM_MUL = 341;
  localparam int CTERM_SHIFT = 10;
endpackage

/* hdl/ecg_smp_if.sv */
// One oversampled window of all channels
interface ecg_smp_if #(parameter int CH = 5, parameter int AW = 24);
  logic vld;
  logic [CH-1:0][AW-1:0] acc;
  logic [1:0] rate;
  modport src(output vld, acc, rate);
  modport dst(input vld, acc, rate);
endinterface

/* hdl/ecg_ovs.sv */
module ecg_ovs import ecg_pkg::*; #(
  parameter int CH = NCH,
  parameter int DW = ADC_W,
  parameter int AW = ACC_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Raw converter samples
  input wire logic [1:0] i_rate,
  input wire logic i_vld,
  input wire logic [CH-1:0][DW-1:0] i_smp,
  // Summed window
  ecg_smp_if.src smp
);
  logic [9:0] cnt_ff;
  logic [9:0] last_cnt;
  logic [3:0] shamt;
  logic last;
  logic vld_ff;
  logic [1:0] rate_ff;

  // Window length per rate; shorter windows are left-aligned to full scale
  always_comb begin
    case (i_rate)
      RATE_16K: begin
        last_cnt = 10'(OVS_16K - 1);
        shamt = 4'($clog2(OVS_2K) - $clog2(OVS_16K));
      end
      RATE_128K: begin
        last_cnt = 10'(OVS_128K - 1);
        shamt = 4'($clog2(OVS_2K) - $clog2(OVS_128K));
      end
      default: begin
        last_cnt = 10'(OVS_2K - 1);
        shamt = 4'h0;
      end
    endcase
  end

  // At-or-above compare keeps a rate change from stranding the counter
  assign last = i_vld && (cnt_ff >= last_cnt);

  // Sample counter
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_ff <= 10'h000;
    end else if (i_vld) begin
      cnt_ff <= last ? 10'h000 : cnt_ff + 10'h001;
    end
  end

  // One accumulator per channel, all dumped on the same sample
  for (genvar g = 0; g < CH; g++) begin : g_ch
    logic [AW-1:0] acc_ff;
    logic [AW-1:0] out_ff;
    logic [AW-1:0] sum;
    assign sum = acc_ff + AW'(i_smp[g]);
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        acc_ff <= '0;
        out_ff <= '0;
      end else if (i_vld) begin
        acc_ff <= last ? '0 : sum;
        if (last) begin
          out_ff <= sum << shamt;
        end
      end
    end
    assign smp.acc[g] = out_ff;
  end

  // Window done strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      vld_ff <= 1'b0;
      rate_ff <= RATE_2K;
    end else begin
      vld_ff <= last;
      if (last) begin
        rate_ff <= i_rate;
      end
    end
  end

  assign smp.vld = vld_ff;
  assign smp.rate = rate_ff;
endmodule

/* tb/ecg_conv_model.sv */
// Converter bank: one result set for each start pulse, after a short or a long delay
module ecg_conv_model import ecg_pkg::*; (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Start pulse, short or long delay choice and analog levels
  input wire logic i_start,
  input wire logic i_slow,
  input wire logic [NCH-1:0][ADC_W-1:0] i_level,
  // Results
  output logic o_vld,
  output logic [NCH-1:0][ADC_W-1:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [6:0] cnt_ff;
  logic busy_ff;

  // Conversion delay stays below the start spacing, so results never crowd each other
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_ff <= 1'b0;
      cnt_ff <= 7'h00;
      o_vld <= 1'b0;
      o_data <= '0;
    end else begin
      o_vld <= 1'b0;
      o_data <= ~o_data; // Released bus toggles so stale data never looks valid
      if (i_start) begin
        busy_ff <= 1'b1;
        cnt_ff <= i_slow ? 7'h28 : 7'h00;
      end else if (busy_ff) begin
        if (cnt_ff == 7'h00) begin
          busy_ff <= 1'b0;
          o_vld <= 1'b1;
          o_data <= i_level;
        end else begin
          cnt_ff <= cnt_ff - 7'h01;
        end
      end
    end
  end
endmodule

/* tb/testbench.sv */
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench import ecg_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic [31:0] rdata;
  logic conv_start;
  logic adc_vld;
  logic frm_vld;
  logic irq;
  logic [31:0] frm_hdr;
  logic [NCH-1:0][ADC_W-1:0] adc_data;
  logic [NCH-1:0][ADC_W-1:0] lvl = {14'h1800, 14'h3000, 14'h2000, 14'h2400, 14'h2100};
  logic [NCH-1:0][OUT_W-1:0] frm_word;
  int num_errors = 0;
  int check_count = 0;
  int gap = 0;

  // 250 MHz core clock
  always #2 clk = ~clk;

  ecg_lead_dp u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_CONV_START(conv_start),
    .I_ADC_VLD(adc_vld), .I_ADC_DATA(adc_data), .O_FRM_VLD(frm_vld), .O_FRM_HDR(frm_hdr),
    .O_FRM_WORD(frm_word), .O_IRQ(irq));

  ecg_conv_model u_conv (.i_clk(clk), .i_rst(rst), .i_start(conv_start), .i_slow(slow),
    .i_level(lvl), .o_vld(adc_vld), .o_data(adc_data));

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One-cycle write strobe; the extra step lets the register update land
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand from the cycle after the strobe until the next read strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  task automatic wait_frame(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin
        @(posedge clk);
        #1;
        k++;
      end while (frm_vld !== 1'b1 && k < 20000);
      if (k >= 20000) `CHK(1'b0, 1'b1)
    end
  endtask

  // Mode 0 electrode, 1 analog lead, 2 digital lead; window sums scale to level times 1024
  task automatic chk_frame(input int mode, input logic [31:0] hdr);
    longint c[NCH];
    longint w[NCH];
    longint cterm;
    longint avf;
    for (int i = 0; i < NCH; i++) begin
      c[i] = (longint'(lvl[i]) <<< 10) - longint'(REF_RST);
      w[i] = c[i];
    end
    if (mode == 1) w[1] = -c[CH_LL];
    if (mode == 2) begin
      cterm = ((c[CH_RA] + c[CH_LA] + c[CH_LL]) * CTERM_MUL) >>> CTERM_SHIFT;
      w[0] = c[CH_LA] - c[CH_RA];
      w[1] = c[CH_LL] - c[CH_RA];
      w[2] = c[CH_LL] - c[CH_LA];
      w[3] = c[CH_V1] - cterm;
      w[4] = c[CH_V2] - cterm;
    end
    // First frame may straddle the last change, so judge the second
    wait_frame(2);
    `CHK(frm_hdr, hdr)
    for (int i = 0; i < NCH; i++) `CHK(frm_word[i], w[i][31:0])
    // Host side forms the augmented foot lead from leads two and three
    if (mode == 2) begin
      avf = (longint'($signed(frm_word[1])) + longint'($signed(frm_word[2]))) >>> 1;
      `CHK(avf, (2 * c[CH_LL] - c[CH_LA] - c[CH_RA]) >>> 1)
    end
    // Status follows the frame pulse by one cycle
    @(posedge clk);
    #1;
  endtask

  // Hang guard, well past the expected run length
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    reg_rd(REG_UTH, 32'h00003f00);
    reg_rd(REG_LTH, 32'h000000ff);
    reg_rd(REG_REF, 32'h005c71c7);
    reg_rd(REG_STS, 32'h0);
    reg_rd(REG_IRQ_CLR, 32'h0);
    reg_rd(8'h7f, 32'h0);
    // Start pulses keep the 2 MHz pacing
    do begin
      @(posedge clk);
      #1;
    end while (conv_start !== 1'b1);
    do begin
      @(posedge clk);
      #1;
      gap++;
    end while (conv_start !== 1'b1 && gap < 200);
    `CHK(gap, CONV_CYC)
    // Digital leads at 16 kHz with a common-electrode setting that must be ignored
    reg_wr(REG_CMREF, 32'h00000100);
    reg_wr(REG_FRM_CTL, 32'h00000001);
    chk_frame(2, 32'h08);
    reg_wr(REG_CMREF, 32'h0);
    // Electrode words at 128 kHz
    reg_wr(REG_FRM_CTL, 32'h00000012);
    reg_rd(REG_FRM_CTL, 32'h00000012);
    chk_frame(0, 32'h12);
    // Analog leads at 128 kHz with slow converters
    slow <= 1'b1;
    reg_wr(REG_ECG_CTL, 32'h00000400);
    reg_wr(REG_FRM_CTL, 32'h00000002);
    chk_frame(1, 32'h14);
    slow <= 1'b0;
    // Digital leads asked for at 128 kHz fall back to electrode words
    reg_wr(REG_ECG_CTL, 32'h0);
    chk_frame(0, 32'h32);
    // Over the upper threshold, interrupt raised then masked
    reg_wr(REG_FRM_CTL, 32'h00000012);
    reg_wr(REG_IRQ_EN, 32'h00000002);
    lvl[CH_V2] = 14'h3f01;
    chk_frame(0, 32'h13);
    `CHK(irq, 1'b1)
    reg_wr(REG_IRQ_EN, 32'h0);
    `CHK(irq, 1'b0)
    // Raised upper threshold puts the same sample back in range
    reg_wr(REG_UTH, 32'h00003f80);
    chk_frame(0, 32'h12);
    reg_wr(REG_IRQ_CLR, 32'h00000007);
    reg_rd(REG_STS, 32'h0);
    reg_wr(REG_IRQ_EN, 32'h00000002);
    `CHK(irq, 1'b0)
    // Under the lower threshold gives a negative word as well
    lvl[CH_RA] = 14'h00fe;
    chk_frame(0, 32'h13);
    `CHK(irq, 1'b1)
    reg_rd(REG_STS, 32'h00000003);
    close_out();
  end
endmodule
